// ==== verilog/sram_ctrl_regs.vh ====
// timing constants for the asynchronous 64k x 4 memory controller
`ifndef SRAM_CTRL_REGS_VH
`define SRAM_CTRL_REGS_VH
`define CLK_PERIOD_PS 5000
// slowest speed grade figures, in picoseconds
`define CYCLE_TIME_PS 12000
`define ADDRESS_TO_DATA_DELAY_PS 12000
`define SELECT_TO_DATA_DELAY_PS 12000
`define DESELECT_TO_FLOAT_DELAY_PS 6000
`define STROBE_PULSE_WIDTH_PS 10000
`define ADDRESS_TO_STROBE_END_PS 10000
`define DATA_SETUP_TO_STROBE_END_PS 6000
`define STROBE_TO_FLOAT_DELAY_PS 6000
`define STROBE_END_TO_DRIVE_DELAY_PS 3000
`define SELECT_PULSE_WIDTH_PS 9000
// least times round up to whole cycles
`define CYC_UP(t) (((t) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define READ_WAIT_CYC `CYC_UP(`SELECT_TO_DATA_DELAY_PS)
`define FLOAT_WAIT_CYC `CYC_UP(`DESELECT_TO_FLOAT_DELAY_PS)
`define STROBE_CYC `CYC_UP(`STROBE_PULSE_WIDTH_PS)
`define STROBE_FLOAT_CYC `CYC_UP(`STROBE_TO_FLOAT_DELAY_PS)
`endif

// ==== verilog/sram_delay_count.v ====
// down counter that signals when a loaded wait has elapsed
`timescale 1ns/1ps
module sram_delay_count #(
  parameter WIDTH = 4
) (
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire load_i,
  input wire [WIDTH-1:0] value_i,
  output wire done_o
);
  reg [WIDTH-1:0] count_q;
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      count_q <= {WIDTH{1'b0}};
    else if (load_i)
      count_q <= value_i;
    else if (count_q != {WIDTH{1'b0}})
      count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
  end
  assign done_o = (count_q == {WIDTH{1'b0}}) && !load_i;
endmodule // sram_delay_count

// ==== verilog/sram_host_ctrl.v ====
// host controller driving an asynchronous 64k x 4 static memory
`timescale 1ns/1ps
`include "sram_ctrl_regs.vh"
module sram_host_ctrl #(
  parameter ADDR_WIDTH = 16,
  parameter DATA_WIDTH = 4
) (
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire req_valid_i,
  input wire req_write_i,
  input wire [ADDR_WIDTH-1:0] req_addr_i,
  input wire [DATA_WIDTH-1:0] req_wdata_i,
  output reg req_ready_o,
  output reg rsp_valid_o,
  output reg [DATA_WIDTH-1:0] rsp_rdata_o,
  output reg [ADDR_WIDTH-1:0] word_address_o,
  output reg chip_select_n_o,
  output reg output_enable_n_o,
  output reg write_strobe_n_o,
  input wire [DATA_WIDTH-1:0] data_bus_i,
  output reg [DATA_WIDTH-1:0] data_bus_o,
  output reg data_bus_oe_o
);
  localparam ST_IDLE = 3'h0;
  localparam ST_READ = 3'h1;
  localparam ST_RFLOAT = 3'h2;
  localparam ST_WSTROBE = 3'h3;
  localparam ST_WEND = 3'h4;
  localparam ST_WFLOAT = 3'h5;
  // whole-cycle counts, cut to the counter width
  localparam integer READ_WAIT_N = `READ_WAIT_CYC;
  localparam integer FLOAT_WAIT_N = `FLOAT_WAIT_CYC;
  localparam integer STROBE_WAIT_N = `STROBE_CYC;
  localparam integer STROBE_FLOAT_N = `STROBE_FLOAT_CYC;
  localparam [3:0] READ_WAIT = READ_WAIT_N[3:0];
  localparam [3:0] FLOAT_WAIT = FLOAT_WAIT_N[3:0];
  localparam [3:0] STROBE_WAIT = STROBE_WAIT_N[3:0];
  localparam [3:0] STROBE_FLOAT_WAIT = STROBE_FLOAT_N[3:0];

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg load_q;
  reg load_d;
  reg [3:0] load_val_q;
  reg [3:0] load_val_d;
  // next values of the registered outputs
  reg ready_d;
  reg rsp_valid_d;
  reg [DATA_WIDTH-1:0] rdata_d;
  reg [ADDR_WIDTH-1:0] address_d;
  reg select_n_d;
  reg read_en_n_d;
  reg strobe_n_d;
  reg [DATA_WIDTH-1:0] bus_data_d;
  reg bus_drive_d;
  wire wait_done;

  sram_delay_count #(
    .WIDTH(4)
  ) u_wait (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(load_q),
    .value_i(load_val_q),
    .done_o(wait_done)
  );

  always @*
  begin
    state_d = state_q;
    load_d = 1'b0;
    load_val_d = load_val_q;
    ready_d = 1'b0;
    rsp_valid_d = 1'b0;
    rdata_d = rsp_rdata_o;
    address_d = word_address_o;
    select_n_d = chip_select_n_o;
    read_en_n_d = output_enable_n_o;
    strobe_n_d = write_strobe_n_o;
    bus_data_d = data_bus_o;
    bus_drive_d = data_bus_oe_o;
    case (state_q)
      ST_IDLE:
      begin
        if (req_valid_i && req_ready_o)
        begin
          // address set at select fall, held through cycle
          address_d = req_addr_i;
          select_n_d = 1'b0;
          load_d = 1'b1;
          if (req_write_i)
          begin
            // strobe falls with select so memory never drives
            strobe_n_d = 1'b0;
            read_en_n_d = 1'b1;
            // data captured now, driven once memory floats
            bus_data_d = req_wdata_i;
            load_val_d = STROBE_WAIT;
            state_d = ST_WSTROBE;
          end
          else
          begin
            strobe_n_d = 1'b1;
            read_en_n_d = 1'b0;
            load_val_d = READ_WAIT;
            state_d = ST_READ;
          end
        end
        else
          ready_d = 1'b1;
      end
      ST_READ:
      begin
        // sample after access time and cycle time
        if (wait_done && !load_q)
        begin
          rdata_d = data_bus_i;
          rsp_valid_d = 1'b1;
          select_n_d = 1'b1;
          read_en_n_d = 1'b1;
          load_d = 1'b1;
          load_val_d = FLOAT_WAIT;
          state_d = ST_RFLOAT;
        end
      end
      ST_RFLOAT:
      begin
        // wait for memory to release the bus before any drive
        if (wait_done && !load_q)
        begin
          ready_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_WSTROBE:
      begin
        // drive data only once memory has floated
        if (!load_q && !data_bus_oe_o)
          bus_drive_d = 1'b1;
        // strobe width covers address, select and data setup
        if (wait_done && !load_q && data_bus_oe_o)
        begin
          // select and strobe rise together, output stays float
          strobe_n_d = 1'b1;
          select_n_d = 1'b1;
          state_d = ST_WEND;
        end
      end
      ST_WEND:
      begin
        // data held one cycle past write end
        bus_drive_d = 1'b0;
        load_d = 1'b1;
        load_val_d = STROBE_FLOAT_WAIT;
        state_d = ST_WFLOAT;
      end
      ST_WFLOAT:
      begin
        if (wait_done && !load_q)
        begin
          ready_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= ST_IDLE;
      load_q <= 1'b0;
      load_val_q <= 4'h0;
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= {DATA_WIDTH{1'b0}};
      word_address_o <= {ADDR_WIDTH{1'b0}};
      chip_select_n_o <= 1'b1;
      output_enable_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      data_bus_o <= {DATA_WIDTH{1'b0}};
      data_bus_oe_o <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      load_q <= load_d;
      load_val_q <= load_val_d;
      req_ready_o <= ready_d;
      rsp_valid_o <= rsp_valid_d;
      rsp_rdata_o <= rdata_d;
      word_address_o <= address_d;
      chip_select_n_o <= select_n_d;
      output_enable_n_o <= read_en_n_d;
      write_strobe_n_o <= strobe_n_d;
      data_bus_o <= bus_data_d;
      data_bus_oe_o <= bus_drive_d;
    end
  end
endmodule // sram_host_ctrl

// ==== testbench/sram_model.sv ====
// behavioural model of the 64k x 4 asynchronous memory
`timescale 1ns/1ps
module sram_model (
  input wire [15:0] addr_i,
  input wire cs_n_i,
  input wire oe_n_i,
  input wire we_n_i,
  input wire [3:0] d_i,
  output wire [3:0] q_o
);
  reg [3:0] mem [0:65535];
  reg [3:0] last_q = 4'h0;
  localparam ACCESS_NS = 12;
  wire rd_en = !cs_n_i && !oe_n_i && we_n_i;
  wire wr_on = !cs_n_i && !we_n_i;
  // released bus shows the inverted last value
  wire [3:0] q_now = rd_en ? mem[addr_i] : ~last_q;
  // new data settles only after the slowest access time, old data stays meanwhile
  assign #(ACCESS_NS) q_o = q_now;
  always @*
    if (rd_en)
      last_q = mem[addr_i];
  always @(negedge wr_on)
    mem[addr_i] <= d_i;
endmodule // sram_model

// ==== testbench/sram_host_ctrl_sva.sv ====
// pin timing assertions for the memory host controller
`timescale 1ns/1ps
module sram_host_ctrl_sva (
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire req_ready_o,
  input wire rsp_valid_o,
  input wire [15:0] word_address_o,
  input wire chip_select_n_o,
  input wire output_enable_n_o,
  input wire write_strobe_n_o,
  input wire data_bus_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_read_strobe_high: assert property (!output_enable_n_o |-> write_strobe_n_o)
    else $error("strobe low in read");
  a_read_addr_hold: assert property ($fell(chip_select_n_o) && write_strobe_n_o |=> $stable(word_address_o)[*3])
    else $error("read address moved");
  a_read_answer: assert property ($fell(chip_select_n_o) && write_strobe_n_o |-> !rsp_valid_o[*5] ##1 rsp_valid_o)
    else $error("read answer late");
  a_float_wait: assert property ($rose(chip_select_n_o) |-> !req_ready_o[*2])
    else $error("ready before float");
  a_strobe_width: assert property ($fell(write_strobe_n_o) |-> !write_strobe_n_o[*2])
    else $error("strobe too short");
  a_write_overlap: assert property (!write_strobe_n_o |-> !chip_select_n_o)
    else $error("strobe without select");
  a_drive_late: assert property ($rose(data_bus_oe_o) |-> !write_strobe_n_o && !$past(write_strobe_n_o))
    else $error("bus driven early");
  a_data_setup: assert property ($rose(write_strobe_n_o) |-> data_bus_oe_o && $past(data_bus_oe_o, 2))
    else $error("data setup short");
  cover property (rsp_valid_o);
  cover property ($rose(data_bus_oe_o));
  cover property ($rose(chip_select_n_o));
endmodule // sram_host_ctrl_sva
bind sram_host_ctrl sram_host_ctrl_sva sram_host_ctrl_sva_i (
  .sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i),
  .req_ready_o(req_ready_o),
  .rsp_valid_o(rsp_valid_o),
  .word_address_o(word_address_o),
  .chip_select_n_o(chip_select_n_o),
  .output_enable_n_o(output_enable_n_o),
  .write_strobe_n_o(write_strobe_n_o),
  .data_bus_oe_o(data_bus_oe_o)
);

// ==== testbench/async_sram_64kx4_access_tb.sv ====
// self-checking bench for the memory host controller
`timescale 1ns/1ps
module async_sram_64kx4_access_tb;
  reg sys_clk_i = 0;
  reg sys_rst_i = 1;
  reg vld = 0;
  reg wr = 0;
  reg [15:0] adr = 16'h0000;
  reg [3:0] wd = 4'h0;
  wire rdy, rv, cs_n, oe_n, we_n, doe;
  wire [3:0] rd, dq, mq;
  wire [15:0] wa;
  wire [3:0] bus = doe ? dq : mq;
  integer bad_count = 0, tests_run = 0, cyc = 0, i;
  reg [19:0] rows [0:3];
  sram_host_ctrl sram_host_ctrl_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(vld), .req_write_i(wr),
    .req_addr_i(adr), .req_wdata_i(wd), .req_ready_o(rdy), .rsp_valid_o(rv), .rsp_rdata_o(rd), .word_address_o(wa),
    .chip_select_n_o(cs_n), .output_enable_n_o(oe_n), .write_strobe_n_o(we_n), .data_bus_i(bus), .data_bus_o(dq),
    .data_bus_oe_o(doe));
  sram_model sram_model_i (.addr_i(wa), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n), .d_i(bus), .q_o(mq));
  initial
    forever #2.5 sys_clk_i = ~sys_clk_i;
  task results;
    begin
      $display("tests %0d errors %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [15:0] g, input [15:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e)
      begin
        bad_count = bad_count + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task chk_pins(input [4:0] g, input [4:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e)
      begin
        bad_count = bad_count + 1;
        $display("ERROR t=%0t pins got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // waits for ready, holds the request over the take edge
  task req(input w, input [15:0] a, input [3:0] d);
    begin
      while (rdy !== 1'b1)
        @(posedge sys_clk_i) #1;
      vld = 1;
      wr = w;
      adr = a;
      wd = d;
      @(posedge sys_clk_i) #1;
      vld = 0;
      while (w == 0 && rv !== 1'b1)
        @(posedge sys_clk_i) #1;
    end
  endtask
  always @(posedge sys_clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 1000)
    begin
      bad_count = bad_count + 1;
      results;
    end
  end
  initial
  begin
    rows[0] = 20'h00000;
    rows[1] = 20'hFFFFF;
    rows[2] = 20'h55555;
    rows[3] = 20'hAAAAA;
    repeat (10) @(posedge sys_clk_i);
    #1 sys_rst_i = 0;
    @(posedge sys_clk_i) #1;
    chk_pins({rdy, cs_n, oe_n, we_n, doe}, 5'h1E);
    // rows written first, then read back in the same order
    for (i = 0; i < 8; i = i + 1)
    begin
      req(i < 4, rows[i % 4][19:4], rows[i % 4][3:0]);
      if (i >= 4)
        chk(rd, rows[i % 4][3:0]);
    end
    $display("row tests done");
    req(1, 16'hFFFF, 4'h6);
    req(0, 16'hFFFF, 4'h0);
    chk(rd, 4'h6);
    req(1, 16'h1234, 4'h3);
    sys_rst_i = 1;
    repeat (2) @(posedge sys_clk_i) #1;
    chk_pins({rdy, cs_n, oe_n, we_n, doe}, 5'h0E);
    sys_rst_i = 0;
    @(posedge sys_clk_i) #1;
    chk_pins({rdy, cs_n, oe_n, we_n, doe}, 5'h1E);
    req(0, 16'hFFFF, 4'h0);
    chk(rd, 4'h6);
    $display("reset tests done");
    results;
  end
endmodule // async_sram_64kx4_access_tb
